// *** rtl/pfrs_top.sv ***
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
module pfrs_top #(
  parameter bit LARGE = 1'b1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        halt_sleep,
  input  wire logic        halt_idle,
  input  wire logic        std_timer_out,
  input  wire logic        std_timer_out_inv,
  input  wire logic        periodic_timer_out,
  input  wire logic        periodic_timer_out_inv,
  input  wire logic [7:0]  porta_pin_in,
  input  wire logic [5:0]  portb_pin_in,
  output logic [7:0]       porta_pin_out,
  output logic [7:0]       porta_pin_oe,
  output logic [5:0]       portb_pin_out,
  output logic [5:0]       portb_pin_oe,
  output logic             ext_irq_in,
  output logic             std_timer_clk_in,
  output logic             std_timer_capture_in,
  output logic             periodic_timer_clk_in,
  output logic             periodic_timer_capture_in,
  output logic             wake_up
);
  import pfrs_pkg::*;

  logic [7:0] porta_data;
  logic [7:0] porta_dir;
  logic [7:0] portb_data;
  logic [7:0] portb_dir;
  logic [7:0] pa_wake;
  logic [7:0] port_a_share_select;
  logic [7:0] port_b_share_select;
  logic [7:0] input_remap_select;
  logic [7:0] reset_pin_control;
  pfrs_mode_t mode;
  logic       wake_seen;
  logic [7:0] pa_sync;
  logic [5:0] pb_sync;
  logic [7:0] pa_prev;

  // Write channel holding slots, taken in either order
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  pfrs_sync #(.W(8)) u_sync_a (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (porta_pin_in),
    .q       (pa_sync)
  );

  pfrs_sync #(.W(6)) u_sync_b (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (portb_pin_in),
    .q       (pb_sync)
  );

  // Per-variant masks: unimplemented bits store nothing and read zero
  wire [7:0] pa_share_mask = LARGE ? PFRS_PA_SHARE_LARGE : PFRS_PA_SHARE_SMALL;
  wire [7:0] remap_mask    = LARGE ? PFRS_REMAP_LARGE : PFRS_REMAP_SMALL;
  wire [7:0] pb_share_mask = LARGE ? PFRS_PB_SHARE_MASK : PFRS_RST_ZERO;

  wire aw_now  = aw_held | s_axi_awvalid;
  wire w_now   = w_held | s_axi_wvalid;
  wire do_wr   = aw_now & w_now & ~s_axi_bvalid;
  wire [7:0]  wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0]  wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire        wr_b0   = do_wr & wr_strb[0];
  wire        wr_b1   = do_wr & wr_strb[1];
  wire [7:0]  wbyte   = wr_data[7:0];

  wire wr_pa_d   = wr_b0 & (wr_addr == PFRS_OFS_PORTA_DATA);
  wire wr_pa_c   = wr_b0 & (wr_addr == PFRS_OFS_PORTA_DIR);
  wire wr_pb_d   = wr_b0 & (wr_addr == PFRS_OFS_PORTB_DATA) & LARGE;
  wire wr_pb_c   = wr_b0 & (wr_addr == PFRS_OFS_PORTB_DIR) & LARGE;
  wire wr_wake   = wr_b0 & (wr_addr == PFRS_OFS_PA_WAKE);
  wire wr_pas    = wr_b0 & (wr_addr == PFRS_OFS_PA_SHARE);
  wire wr_pbs    = wr_b0 & (wr_addr == PFRS_OFS_PB_SHARE);
  wire wr_remap  = wr_b0 & (wr_addr == PFRS_OFS_REMAP);
  wire wr_rstpin = wr_b0 & (wr_addr == PFRS_OFS_RST_PIN);
  wire wr_bitop  = wr_b0 & wr_b1 & (wr_addr == PFRS_OFS_BIT_OP);

  wire wr_known = (wr_addr <= PFRS_OFS_BIT_OP) & (wr_addr[1:0] == 2'b00);

  // Bit op: [2:0] bit index, [3] set/clear, [9:8] port register
  wire [2:0]   bit_idx = wr_data[2:0];
  wire         bit_val = wr_data[PFRS_BIT_OP_POS];
  pfrs_port_t  bit_reg;
  assign bit_reg = pfrs_port_t'(wr_data[PFRS_BIT_REG_LSB +: 2]);
  wire [7:0]   bit_one = 8'h01 << bit_idx;

  // Whole register read, one bit changed, whole value written back
  wire [7:0] rmw_src = (bit_reg == PFRS_PA_DATA) ? porta_data :
                       (bit_reg == PFRS_PA_DIR)  ? porta_dir  :
                       (bit_reg == PFRS_PB_DATA) ? portb_data : portb_dir;
  wire [7:0] rmw_val = bit_val ? (rmw_src | bit_one) : (rmw_src & ~bit_one);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      porta_data <= PFRS_RST_PORT;
      porta_dir  <= PFRS_RST_PORT;
      portb_data <= PFRS_RST_PORT & PFRS_PB_MASK;
      portb_dir  <= PFRS_RST_PORT & PFRS_PB_MASK;
    end else if (wr_bitop) begin
      if (bit_reg == PFRS_PA_DATA) porta_data <= rmw_val;
      if (bit_reg == PFRS_PA_DIR)  porta_dir  <= rmw_val;
      if (bit_reg == PFRS_PB_DATA && LARGE) portb_data <= rmw_val & PFRS_PB_MASK;
      if (bit_reg == PFRS_PB_DIR && LARGE)  portb_dir  <= rmw_val & PFRS_PB_MASK;
    end else begin
      if (wr_pa_d) porta_data <= wbyte;
      if (wr_pa_c) porta_dir  <= wbyte;
      if (wr_pb_d) portb_data <= wbyte & PFRS_PB_MASK;
      if (wr_pb_c) portb_dir  <= wbyte & PFRS_PB_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa_wake             <= PFRS_RST_ZERO;
      port_a_share_select <= PFRS_RST_ZERO;
      port_b_share_select <= PFRS_RST_ZERO;
      input_remap_select  <= PFRS_RST_ZERO;
      reset_pin_control   <= PFRS_RST_PIN_RESET;
    end else begin
      if (wr_wake)   pa_wake <= wbyte;
      if (wr_pas)    port_a_share_select <= wbyte & pa_share_mask;
      if (wr_pbs)    port_b_share_select <= wbyte & pb_share_mask;
      if (wr_remap)  input_remap_select  <= wbyte & remap_mask;
      if (wr_rstpin) reset_pin_control   <= wbyte;
    end
  end

  // Sleep/idle entry and wake on a falling edge of an enabled port A pin
  wire [7:0] pa_fall   = pa_prev & ~pa_sync & pa_wake;
  wire       wake_hit  = (mode != PFRS_AWAKE) & (|pa_fall);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode      <= PFRS_AWAKE;
      pa_prev   <= PFRS_RST_PORT;
      wake_up   <= 1'b0;
      wake_seen <= 1'b0;
    end else begin
      pa_prev <= pa_sync;
      wake_up <= wake_hit;
      unique case (mode)
        PFRS_AWAKE: begin
          if (halt_sleep) mode <= PFRS_SLEEP;
          else if (halt_idle) mode <= PFRS_IDLE;
        end
        PFRS_SLEEP, PFRS_IDLE: begin
          if (wake_hit) mode <= PFRS_AWAKE;
        end
        default: mode <= PFRS_AWAKE;
      endcase
      // Sticky record; a new wake wins over a clear in the same cycle
      if (wake_hit) wake_seen <= 1'b1;
      else if (wr_b0 & (wr_addr == PFRS_OFS_STATUS) & wbyte[0]) wake_seen <= 1'b0;
    end
  end

  // Pin output selection
  wire pa_sel7 = port_a_share_select[7] & (reset_pin_control == PFRS_RST_PIN_IO);
  // Large: A7 inverted, A6 and A4 plain; small: A5, A2, A1, A0 alternate
  wire [7:0] pa_en_l    = {pa_sel7, port_a_share_select[6], 1'b0,
                           port_a_share_select[5], 4'h0};
  wire [7:0] pa_val_l   = {std_timer_out_inv, std_timer_out, 1'b0, std_timer_out, 4'h0};
  wire [7:0] pa_en_s    = {2'b00, port_a_share_select[6], 2'b00, port_a_share_select[4],
                           port_a_share_select[2], port_a_share_select[0]};
  wire [7:0] pa_val_s   = {2'b00, std_timer_out_inv, 2'b00, std_timer_out,
                           std_timer_out_inv, std_timer_out};
  wire [7:0] pa_alt_en  = LARGE ? pa_en_l : pa_en_s;
  wire [7:0] pa_alt_val = LARGE ? pa_val_l : pa_val_s;
  wire [5:0] pb_alt_en  = LARGE ? {port_b_share_select[5:1], 1'b0} : 6'h00;
  wire [5:0] pb_alt_val = {periodic_timer_out, periodic_timer_out_inv, periodic_timer_out,
                           periodic_timer_out_inv, std_timer_out_inv, 1'b0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      porta_pin_out <= PFRS_RST_PORT;
      porta_pin_oe  <= PFRS_RST_ZERO;
      portb_pin_out <= PFRS_RST_PORT[5:0];
      portb_pin_oe  <= PFRS_RST_ZERO[5:0];
    end else begin
      porta_pin_out <= (pa_alt_en & pa_alt_val) | (~pa_alt_en & porta_data);
      porta_pin_oe  <= pa_alt_en | ~porta_dir;
      portb_pin_out <= (pb_alt_en & pb_alt_val) | (~pb_alt_en & portb_data[5:0]);
      portb_pin_oe  <= LARGE ? (pb_alt_en | ~portb_dir[5:0]) : 6'h00;
    end
  end

  // Input remapping
  wire [3:0] irq_src_l = {pa_sync[5], pa_sync[4], pa_sync[2], pa_sync[3]};
  wire [3:0] irq_src_s = {pa_sync[7], pa_sync[3], pa_sync[2], pa_sync[5]};
  wire [3:0] ptck_src  = {pb_sync[1], pa_sync[7], pa_sync[6], pa_sync[4]};

  pfrs_mux4 u_irq (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sel     (input_remap_select[1:0]),
    .src     (LARGE ? irq_src_l : irq_src_s),
    .y       (ext_irq_in)
  );

  pfrs_mux4 u_ptck (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sel     (input_remap_select[7:6]),
    .src     (ptck_src),
    .y       (periodic_timer_clk_in)
  );

  wire stck_l = input_remap_select[5] ? pa_sync[2] : pa_sync[3];
  wire stck_s = input_remap_select[5] ? pa_sync[6] : pa_sync[7];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      std_timer_clk_in          <= 1'b1;
      std_timer_capture_in      <= 1'b1;
      periodic_timer_capture_in <= 1'b1;
    end else begin
      std_timer_clk_in     <= LARGE ? stck_l : stck_s;
      std_timer_capture_in <= input_remap_select[4] ? pa_sync[0] : pa_sync[6];
      periodic_timer_capture_in <= input_remap_select[3] ? pb_sync[0] : pa_sync[5];
    end
  end

  // AXI4-Lite write side; readies registered from next-state terms, same timing as gates
  wire next_bvalid  = do_wr | (s_axi_bvalid & ~s_axi_bready);
  wire next_aw_held = (s_axi_awvalid & s_axi_awready) ? ~do_wr : (aw_held & ~do_wr);
  wire next_w_held  = (s_axi_wvalid & s_axi_wready) ? ~do_wr : (w_held & ~do_wr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      s_axi_awready <= ~next_aw_held & ~next_bvalid;
      s_axi_wready  <= ~next_w_held & ~next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (s_axi_awvalid & s_axi_awready) aw_addr <= s_axi_awaddr;
      if (s_axi_wvalid & s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) s_axi_bresp <= wr_known ? 2'b00 : 2'b10;
    end
  end

  // AXI4-Lite read side, one cycle after address
  logic [7:0] rd_byte;
  logic       rd_ok;

  always_comb begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      PFRS_OFS_PORTA_DATA: rd_byte = porta_data;
      PFRS_OFS_PORTA_DIR:  rd_byte = porta_dir;
      PFRS_OFS_PORTB_DATA: rd_byte = portb_data;
      PFRS_OFS_PORTB_DIR:  rd_byte = portb_dir;
      PFRS_OFS_PA_WAKE:    rd_byte = pa_wake;
      PFRS_OFS_PA_SHARE:   rd_byte = port_a_share_select;
      PFRS_OFS_PB_SHARE:   rd_byte = port_b_share_select;
      PFRS_OFS_REMAP:      rd_byte = input_remap_select;
      PFRS_OFS_RST_PIN:    rd_byte = reset_pin_control;
      PFRS_OFS_BIT_OP:     rd_byte = 8'h00;
      PFRS_OFS_STATUS:     rd_byte = {5'h00, mode, wake_seen};
      PFRS_OFS_PORTA_PIN:  rd_byte = pa_sync;
      PFRS_OFS_PORTB_PIN:  rd_byte = {2'b00, pb_sync};
      default: begin
        rd_byte = 8'h00;
        rd_ok   = 1'b0;
      end
    endcase
  end

  wire next_rvalid = (s_axi_arvalid & s_axi_arready) | (s_axi_rvalid & ~s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_rvalid  <= next_rvalid;
      s_axi_arready <= ~next_rvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rdata <= {24'h0, rd_byte};
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end
    end
  end
endmodule

// *** rtl/pfrs_pkg.sv ***
// What this block does
// - Large variant: share bit 7 routes inverted standard output, bits 6 and 5 the plain one.
// - Share bit 7 only takes effect while the reset-pin control register holds 55h.
// - In the large variant, port A share bits 4 to 0 read as zero and ignore writes.
// - In the large variant, port B share bits 5,3 give periodic out, 4,2 its inverse, bit 1 inverted standard out.
// - In the large variant, remap bits 7:6 pick the periodic clock input from A4, A6, A7 or B1.
// - In the large variant, remap bit 5 picks the standard clock input from A3 or A2.
// - Remap bit 4 picks the standard capture input from A6 or A0 in both variants.
// - In the large variant, remap bit 3 picks the periodic capture input from A5 or B0.
// - In the large variant, remap bits 1:0 pick the interrupt input from A3, A2, A4 or A5.
// - In the small variant, remap bits 1:0 pick the interrupt input from A5, A2, A3 or A7.
// - Small variant: remap bit 5 picks standard clock input A7 or A6; bits 7,6,3,2 read zero.
// - Reset sets every port data and direction bit high.
// - Bit set and clear on a port register read the whole port, change one bit and write it back.
// - In sleep or idle, a falling edge on any wake-enabled port A pin wakes the device.
package pfrs_pkg;
  localparam logic [7:0] PFRS_OFS_PORTA_DATA  = 8'h00;
  localparam logic [7:0] PFRS_OFS_PORTA_DIR   = 8'h04;
  localparam logic [7:0] PFRS_OFS_PORTB_DATA  = 8'h08;
  localparam logic [7:0] PFRS_OFS_PORTB_DIR   = 8'h0c;
  localparam logic [7:0] PFRS_OFS_PA_WAKE     = 8'h10;
  localparam logic [7:0] PFRS_OFS_PA_SHARE    = 8'h14;
  localparam logic [7:0] PFRS_OFS_PB_SHARE    = 8'h18;
  localparam logic [7:0] PFRS_OFS_REMAP       = 8'h1c;
  localparam logic [7:0] PFRS_OFS_RST_PIN     = 8'h20;
  localparam logic [7:0] PFRS_OFS_BIT_OP      = 8'h24;
  localparam logic [7:0] PFRS_OFS_STATUS      = 8'h28;
  localparam logic [7:0] PFRS_OFS_PORTA_PIN   = 8'h2c;
  localparam logic [7:0] PFRS_OFS_PORTB_PIN   = 8'h30;

  localparam logic [7:0] PFRS_RST_PORT        = 8'hff;
  localparam logic [7:0] PFRS_RST_ZERO        = 8'h00;
  localparam logic [7:0] PFRS_RST_PIN_RESET   = 8'h00;
  localparam logic [7:0] PFRS_RST_PIN_IO      = 8'h55;

  localparam logic [7:0] PFRS_PA_SHARE_LARGE  = 8'he0;
  localparam logic [7:0] PFRS_PA_SHARE_SMALL  = 8'h55;
  localparam logic [7:0] PFRS_PB_SHARE_MASK   = 8'h3e;
  localparam logic [7:0] PFRS_REMAP_LARGE     = 8'hfb;
  localparam logic [7:0] PFRS_REMAP_SMALL     = 8'h33;
  localparam logic [7:0] PFRS_PB_MASK         = 8'h3f;

  localparam int PFRS_BIT_OP_POS  = 3;
  localparam int PFRS_BIT_SET_POS = 4;
  localparam int PFRS_BIT_REG_LSB = 8;

  typedef enum logic [1:0] {PFRS_AWAKE, PFRS_SLEEP, PFRS_IDLE} pfrs_mode_t;
  typedef enum logic [1:0] {PFRS_PA_DATA, PFRS_PA_DIR, PFRS_PB_DATA, PFRS_PB_DIR} pfrs_port_t;
endpackage

// *** rtl/pfrs_sync.sv ***
module pfrs_sync #(
  parameter int W = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '1;
      q    <= '1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// *** rtl/pfrs_mux4.sv ***
module pfrs_mux4 (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] sel,
  input  wire logic [3:0] src,
  output logic            y
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      y <= 1'b1;
    end else begin
      y <= src[sel];
    end
  end
endmodule

// *** sim/pfrs_props.sv ***
module pfrs_props (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [7:0] porta_pin_in,
  input wire logic [7:0] porta_pin_out,
  input wire logic [7:0] porta_pin_oe,
  input wire logic       ext_irq_in,
  input wire logic       std_timer_clk_in,
  input wire logic       std_timer_capture_in,
  input wire logic       wake_up
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_pins: assert property (disable iff (1'b0) !aresetn |=>
    porta_pin_out == 8'hff && porta_pin_oe == 8'h00) else $error("pins not at reset state");
  a_write_bad_addr: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && s_axi_awaddr > 8'h30 |=> s_axi_bvalid && s_axi_bresp == 2'b10)
    else $error("unmapped write not refused");
  a_read_ok_resp: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr <= 8'h30
    && s_axi_araddr[1:0] == 2'b00 |=> s_axi_rvalid && s_axi_rresp == 2'b00)
    else $error("mapped read answer wrong");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
  a_rresp_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rresp)) else $error("read answer dropped early");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  a_remap_low: assert property ((porta_pin_in == 8'h00) [*5] |->
    !ext_irq_in && !std_timer_clk_in && !std_timer_capture_in) else $error("remap not low");
  a_remap_high: assert property ((porta_pin_in == 8'hff) [*5] |->
    ext_irq_in && std_timer_clk_in && std_timer_capture_in) else $error("remap not high");
  a_wake_pulse: assert property (wake_up |=> !wake_up)
    else $error("wake pulse longer than one cycle");
endmodule

bind pfrs_top pfrs_props u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .porta_pin_in(porta_pin_in),
  .porta_pin_out(porta_pin_out), .porta_pin_oe(porta_pin_oe), .ext_irq_in(ext_irq_in),
  .std_timer_clk_in(std_timer_clk_in), .std_timer_capture_in(std_timer_capture_in),
  .wake_up(wake_up)
);

// *** sim/tb_pin_function_remap_select.sv ***
module tb_pin_function_remap_select;
  timeunit 1ns;
  timeprecision 1ps;
  import pfrs_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn, awvalid, wvalid, bready, arvalid, rready, hs, hi, so, soi, po, poi;
  logic        awready, wready, bvalid, arready, rvalid, irq, sck, scap, pck, pcap, wake;
  logic        s_irq, s_sck, s_scap;
  logic [1:0]  bresp, rresp;
  logic [7:0]  awaddr, araddr, pa_in, pa_out, pa_oe;
  logic [5:0]  pb_in, pb_out, pb_oe;
  logic [31:0] wdata, rdata, s_rdata;
  int          num_errors, n_checks;

  always #4 aclk = ~aclk;

  pfrs_top #(.LARGE(1'b1)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .halt_sleep(hs), .halt_idle(hi), .std_timer_out(so), .std_timer_out_inv(soi),
    .periodic_timer_out(po), .periodic_timer_out_inv(poi), .porta_pin_in(pa_in),
    .portb_pin_in(pb_in), .porta_pin_out(pa_out), .porta_pin_oe(pa_oe),
    .portb_pin_out(pb_out), .portb_pin_oe(pb_oe), .ext_irq_in(irq),
    .std_timer_clk_in(sck), .std_timer_capture_in(scap), .periodic_timer_clk_in(pck),
    .periodic_timer_capture_in(pcap), .wake_up(wake)
  );

  // Small variant shares bus and pins; only remap results and read data are watched
  pfrs_top #(.LARGE(1'b0)) dut_small (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(s_rdata), .s_axi_rresp(),
    .s_axi_rvalid(), .s_axi_rready(rready), .halt_sleep(hs), .halt_idle(hi),
    .std_timer_out(so), .std_timer_out_inv(soi), .periodic_timer_out(po),
    .periodic_timer_out_inv(poi), .porta_pin_in(pa_in), .portb_pin_in(pb_in),
    .porta_pin_out(), .porta_pin_oe(), .portb_pin_out(), .portb_pin_oe(),
    .ext_irq_in(s_irq), .std_timer_clk_in(s_sck), .std_timer_capture_in(s_scap),
    .periodic_timer_clk_in(), .periodic_timer_capture_in(), .wake_up()
  );

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Ready is raised only after the answer shows, so the hold rules get exercised
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (bvalid && bready) break;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b1;
    end
    bready <= 1'b0;
    chk("bresp", e, bresp);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (rvalid && rready) break;
      if (arready) arvalid <= 1'b0;
      if (rvalid) rready <= 1'b1;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk($sformatf("reg %h", a), e, d);
  endtask

  function automatic logic [31:0] bop(input pfrs_port_t g, input logic s, input int b);
    return (32'(g) << PFRS_BIT_REG_LSB) | (32'(s) << PFRS_BIT_OP_POS) | 32'(b);
  endfunction

  function automatic logic [4:0] rexp(input logic [7:0] r, input logic [13:0] p);
    rexp[4] = r[1] ? (r[0] ? p[5] : p[4]) : (r[0] ? p[2] : p[3]);
    rexp[3] = r[5] ? p[2] : p[3];
    rexp[2] = r[4] ? p[0] : p[6];
    rexp[1] = r[7] ? (r[6] ? p[9] : p[7]) : (r[6] ? p[6] : p[4]);
    rexp[0] = r[3] ? p[8] : p[5];
  endfunction

  function automatic logic [2:0] sexp(input logic [7:0] r, input logic [7:0] p);
    sexp[2] = r[1] ? (r[0] ? p[7] : p[3]) : (r[0] ? p[2] : p[5]);
    sexp[1] = r[5] ? p[6] : p[7];
    sexp[0] = r[4] ? p[0] : p[6];
  endfunction

  task automatic t_reset;
    rchk(PFRS_OFS_PORTA_DATA, 8'hff);
    rchk(PFRS_OFS_PORTA_DIR, 8'hff);
    rchk(PFRS_OFS_PORTB_DATA, 8'h3f);
    rchk(PFRS_OFS_PORTB_DIR, 8'h3f);
    rchk(PFRS_OFS_PA_SHARE, 8'h00);
    rchk(PFRS_OFS_REMAP, 8'h00);
    chk("pa oe", 8'h00, pa_oe);
    wr(PFRS_OFS_PORTA_DIR, 8'h00, 2'b00);
    repeat (2) @(posedge aclk);
    chk("pa out", 8'hff, pa_out);
    chk("pa oe", 8'hff, pa_oe);
    wr(PFRS_OFS_PORTA_DATA, 8'h5a, 2'b00);
    repeat (2) @(posedge aclk);
    chk("pa out", 8'h5a, pa_out);
    $display("t_reset done");
  endtask

  task automatic t_bitop;
    wr(PFRS_OFS_BIT_OP, bop(PFRS_PA_DATA, 1'b0, 3), 2'b00);
    wr(PFRS_OFS_BIT_OP, bop(PFRS_PB_DIR, 1'b0, 5), 2'b00);
    wr(PFRS_OFS_BIT_OP, bop(PFRS_PA_DIR, 1'b1, 7), 2'b00);
    rchk(PFRS_OFS_PORTA_DATA, 8'h52);
    rchk(PFRS_OFS_PORTB_DIR, 8'h1f);
    rchk(PFRS_OFS_PORTA_DIR, 8'h80);
    rchk(PFRS_OFS_PORTB_DATA, 8'h3f);
    chk("pa oe", 8'h7f, pa_oe);
    wr(PFRS_OFS_PORTA_DIR, 8'hff, 2'b00);
    wr(PFRS_OFS_PORTB_DIR, 8'h3f, 2'b00);
    $display("t_bitop done");
  endtask

  task automatic t_share;
    int i;
    wr(PFRS_OFS_RST_PIN, PFRS_RST_PIN_IO, 2'b00);
    wr(PFRS_OFS_PA_SHARE, 8'hff, 2'b00);
    wr(PFRS_OFS_PB_SHARE, 8'hff, 2'b00);
    rchk(PFRS_OFS_PA_SHARE, 8'he0);
    rchk(PFRS_OFS_PB_SHARE, 8'h3e);
    for (i = 0; i < 2; i++) begin
      {so, soi, po, poi} <= i ? 4'b1001 : 4'b0110;
      repeat (3) @(posedge aclk);
      chk("pa out", i ? 8'h52 : 8'h82, pa_out);
      chk("pb out", i ? 6'h15 : 6'h2b, pb_out);
      chk("pa oe", 8'hd0, pa_oe);
      chk("pb oe", 6'h3e, pb_oe);
    end
    wr(PFRS_OFS_RST_PIN, PFRS_RST_PIN_RESET, 2'b00);
    repeat (2) @(posedge aclk);
    chk("pa oe", 8'h50, pa_oe);
    wr(PFRS_OFS_PA_SHARE, 8'h00, 2'b00);
    wr(PFRS_OFS_PB_SHARE, 8'h00, 2'b00);
    repeat (2) @(posedge aclk);
    chk("pa out", 8'h52, pa_out);
    chk("oe", 14'h0, {pb_oe, pa_oe});
    $display("t_share done");
  endtask

  task automatic t_remap;
    logic [7:0]  rt [4] = '{8'h00, 8'h79, 8'h82, 8'hfb};
    logic [13:0] p;
    int          k, i;
    for (k = 0; k < 4; k++) begin
      wr(PFRS_OFS_REMAP, rt[k], 2'b00);
      rchk(PFRS_OFS_REMAP, rt[k]);
      chk("small remap reg", rt[k] & 8'h33, s_rdata);
      // Walking zero tells every source pin apart; then all low, all high
      for (i = 0; i < 16; i++) begin
        p = (i < 14) ? ~(14'h1 << i) : ((i == 14) ? 14'h0 : 14'h3fff);
        pa_in <= p[7:0];
        pb_in <= p[13:8];
        repeat (5) @(posedge aclk);
        chk("remap", rexp(rt[k], p), {irq, sck, scap, pck, pcap});
        chk("small remap", sexp(rt[k], p[7:0]), {s_irq, s_sck, s_scap});
      end
    end
    $display("t_remap done");
  endtask

  task automatic pwake(input logic [7:0] pins, input logic e);
    logic seen;
    seen = 1'b0;
    pa_in <= pins;
    repeat (8) begin
      @(posedge aclk);
      if (wake === 1'b1) seen = 1'b1;
    end
    chk("wake", e, seen);
    pa_in <= 8'hff;
    repeat (4) @(posedge aclk);
  endtask

  task automatic t_wake;
    wr(PFRS_OFS_PA_WAKE, 8'h08, 2'b00);
    pwake(8'hf7, 1'b0);
    hs <= 1'b1;
    @(posedge aclk);
    hs <= 1'b0;
    rchk(PFRS_OFS_STATUS, 8'h02);
    pwake(8'hfb, 1'b0);
    pwake(8'hf7, 1'b1);
    rchk(PFRS_OFS_STATUS, 8'h01);
    wr(PFRS_OFS_STATUS, 32'h1, 2'b10);
    rchk(PFRS_OFS_STATUS, 8'h00);
    pwake(8'hf7, 1'b0);
    hi <= 1'b1;
    @(posedge aclk);
    hi <= 1'b0;
    rchk(PFRS_OFS_STATUS, 8'h04);
    pwake(8'hf7, 1'b1);
    $display("t_wake done");
  endtask

  task automatic t_bus;
    logic [31:0] d;
    logic [1:0]  r;
    wr(8'h40, 32'h0, 2'b10);
    wr(PFRS_OFS_PORTA_PIN, 32'h0, 2'b10);
    rd(8'h40, d, r);
    chk("rresp", 2'b10, r);
    rd(PFRS_OFS_PORTA_PIN, d, r);
    chk("rresp", 2'b00, r);
    chk("pins", 8'hff, d);
    $display("t_bus done");
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, hs, hi, so, soi, po, poi} = '0;
    {awaddr, araddr, wdata} = '0;
    pa_in = 8'hff;
    pb_in = 6'h3f;
    aresetn = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_bitop;
    t_share;
    t_remap;
    t_wake;
    t_bus;
    end_of_test;
  end

  // Whole run needs several hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    end_of_test;
  end
endmodule
